// ==== usis_cfg.svh ====
/*
 * Constants of the universal serial shifter: field positions, reset values, widths and codes.
 * Assumes it is included by its bare name from the package and the design modules.
 */
`ifndef USIS_CFG_SVH
`define USIS_CFG_SVH

// ==========================================================
// Widths
`define USIS_DATA_W      8
`define USIS_CNT_W       4
`define USIS_SYNC_W      3

// ==========================================================
// Status word layout
`define USIS_OVF_BIT     6
`define USIS_CNT_MSB     3
`define USIS_CNT_LSB     0
`define USIS_CNT_TOP     4'hf

// ==========================================================
// Reset values
`define USIS_DATA_RST    8'h00
`define USIS_CNT_RST     4'h0

// ==========================================================
// Wire mode codes
`define USIS_WM_NONE     2'h0
`define USIS_WM_THREE    2'h1
`define USIS_WM_TWO      2'h2
`define USIS_WM_TWO_HOLD 2'h3

`endif

// ==== usis_pkg.sv ====
/*
 * Types of the universal serial shifter.
 * Assumes usis_cfg.svh is on the include path.
 */
`include "usis_cfg.svh"

package usis_pkg;

    // ==========================================================
    // Wire modes
    typedef enum logic [1:0] {
        USIS_WM_NONE_E     = `USIS_WM_NONE,
        USIS_WM_THREE_E    = `USIS_WM_THREE,
        USIS_WM_TWO_E      = `USIS_WM_TWO,
        USIS_WM_TWO_HOLD_E = `USIS_WM_TWO_HOLD
    } usis_wire_mode_t;

endpackage : usis_pkg

// ==== usis_sync.sv ====
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes asynchronous inputs; output follows once stages two and three agree.
 */
`timescale 1ns/1ns

module usis_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);

    // ==========================================================
    // Stages
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    // Bit by bit: a lane only moves once two stages agree on it
    assign level_d   = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    assign level_out = level_q;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= async_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

endmodule : usis_sync

// ==== usis_top.sv ====
/*
 * Universal serial shifter: 8-bit shift register, 4-bit edge counter, three-wire and two-wire pins.
 * Assumes the serial clock pin level arrives on link_clk_in and runs at most at an eighth of
 * the system clock rate; control, data and status writes are one-cycle strobes on sys_clk_in.
 */
`timescale 1ns/1ns
`include "usis_cfg.svh"

module usis_top (
    input  wire logic                     sys_clk_in,
    input  wire logic                     arst_n_in,
    input  wire logic                     link_clk_in,
    input  wire logic                     serial_data_in_in,
    input  wire logic [1:0]               wire_mode_in,
    input  wire logic                     external_clock_select_in,
    input  wire logic                     clock_edge_select_in,
    input  wire logic                     ovf_wake_enable_in,
    input  wire logic                     ctrl_wr_in,
    input  wire logic                     shift_strobe_in,
    input  wire logic                     clock_toggle_strobe_in,
    input  wire logic                     data_wr_in,
    input  wire logic [`USIS_DATA_W-1:0]  data_wdata_in,
    input  wire logic                     status_wr_in,
    input  wire logic [`USIS_DATA_W-1:0]  status_wdata_in,
    input  wire logic                     data_dir_in,
    input  wire logic                     clock_dir_in,
    input  wire logic                     start_hold_in,
    output logic      [`USIS_DATA_W-1:0]  shift_data_reg_out,
    output logic      [`USIS_DATA_W-1:0]  serial_status_reg_out,
    output logic                          counter_overflow_flag_out,
    output logic                          idle_wake_out,
    output logic                          data_pin_out,
    output logic                          data_pin_oe_n_out,
    output logic                          sda_pin_out,
    output logic                          sda_pin_oe_n_out,
    output logic                          serial_clock_pin_out,
    output logic                          serial_clock_pin_oe_n_out
);

    // ==========================================================
    // Helpers
    function automatic logic [`USIS_CNT_W:0] usis_cnt_add(input logic [`USIS_CNT_W-1:0] cnt,
                                                         input logic [1:0]             inc);
        usis_cnt_add = {1'b0, cnt} + {{(`USIS_CNT_W-1){1'b0}}, inc};
    endfunction : usis_cnt_add

    // ==========================================================
    // Link domain: capture the input bit at each edge, flag the edge by a toggle
    logic rise_tog_q;
    logic rise_bit_q;
    logic fall_tog_q;
    logic fall_bit_q;

    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rise_tog_q <= 1'b0;
            rise_bit_q <= 1'b0;
        end else begin
            rise_tog_q <= ~rise_tog_q;
            rise_bit_q <= serial_data_in_in;
        end
    end

    always_ff @(negedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fall_tog_q <= 1'b0;
            fall_bit_q <= 1'b0;
        end else begin
            fall_tog_q <= ~fall_tog_q;
            fall_bit_q <= serial_data_in_in;
        end
    end

    // ==========================================================
    // Crossing into the system domain
    // The captured bits are held a whole serial cycle, long after their toggle has crossed
    logic [`USIS_SYNC_W-1:0] sync_lvl;
    logic                    rise_prev_q;
    logic                    fall_prev_q;
    logic                    din_s;
    logic                    rise_ev;
    logic                    fall_ev;

    usis_sync #(
        .W (`USIS_SYNC_W)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .async_in   ({serial_data_in_in, fall_tog_q, rise_tog_q}),
        .level_out  (sync_lvl)
    );

    assign din_s   = sync_lvl[2];
    assign rise_ev = sync_lvl[0] ^ rise_prev_q;
    assign fall_ev = sync_lvl[1] ^ fall_prev_q;

    // ==========================================================
    // Decode
    usis_pkg::usis_wire_mode_t wm;
    logic                      clk_strobe_sel_q;
    logic                      ext_sel;
    logic                      cnt_from_toggle;
    logic                      two_wire;
    logic                      sample_ev;
    logic                      ext_bit;
    logic                      ext_shift;
    logic                      soft_shift;
    logic                      toggle_wr;
    logic                      do_shift;
    logic                      shift_bit;
    logic [1:0]                ext_cnt;
    logic [1:0]                cnt_inc;

    assign wm              = usis_pkg::usis_wire_mode_t'(wire_mode_in);
    assign ext_sel         = external_clock_select_in;
    assign cnt_from_toggle = ext_sel & clk_strobe_sel_q;
    assign two_wire        = (wm == usis_pkg::USIS_WM_TWO_E) || (wm == usis_pkg::USIS_WM_TWO_HOLD_E);
    assign sample_ev       = clock_edge_select_in ? fall_ev : rise_ev;
    assign ext_bit         = clock_edge_select_in ? fall_bit_q : rise_bit_q;
    // The register moves at the sample edge and only the latch waits for the change edge,
    // otherwise the bit taken at the last edge of a mode 1 byte would never be shifted in
    assign ext_shift       = ext_sel & sample_ev;
    assign soft_shift      = ctrl_wr_in & shift_strobe_in & ~ext_sel;
    assign toggle_wr       = ctrl_wr_in & clock_toggle_strobe_in;
    assign do_shift        = ext_shift | soft_shift;
    assign shift_bit       = ext_sel ? ext_bit : din_s;
    assign ext_cnt         = {1'b0, rise_ev} + {1'b0, fall_ev};
    assign cnt_inc         = !ext_sel ? {1'b0, soft_shift}
                           : cnt_from_toggle ? {1'b0, toggle_wr}
                           : ext_cnt;

    // ==========================================================
    // Shift register, counter and flag
    logic [`USIS_DATA_W-1:0] data_q;
    logic [`USIS_DATA_W-1:0] data_d;
    logic [`USIS_CNT_W-1:0]  cnt_q;
    logic [`USIS_CNT_W-1:0]  cnt_d;
    logic [`USIS_CNT_W:0]    cnt_sum;
    logic                    ovf_q;
    logic                    ovf_d;
    logic                    ovf_set;
    logic                    ovf_clr;

    // A write beats a coincident clock event
    assign data_d  = data_wr_in ? data_wdata_in
                   : do_shift ? {data_q[`USIS_DATA_W-2:0], shift_bit}
                   : data_q;
    assign cnt_sum = usis_cnt_add(cnt_q, cnt_inc);
    assign ovf_set = cnt_sum[`USIS_CNT_W];
    assign ovf_clr = status_wr_in & status_wdata_in[`USIS_OVF_BIT];
    assign cnt_d   = status_wr_in ? status_wdata_in[`USIS_CNT_MSB:`USIS_CNT_LSB]
                   : cnt_sum[`USIS_CNT_W-1:0];
    // Set beats clear so an edge arriving with the clear is not lost
    assign ovf_d   = ovf_set | (ovf_q & ~ovf_clr);

    // ==========================================================
    // Output latch
    // Follows the pin level, so a write made between frames reaches the pin at once in mode 0 and under the internal clock, in mode 1 at the next rising edge
    // Limitation: the pin must idle low when reset is released
    logic link_high;
    logic latch_open;
    logic out_q;
    logic out_d;

    assign link_high  = sync_lvl[0] ^ sync_lvl[1];
    assign latch_open = !ext_sel ? 1'b1
                      : clock_edge_select_in ? link_high : ~link_high;
    assign out_d      = latch_open ? data_d[`USIS_DATA_W-1] : out_q;

    // ==========================================================
    // Serial clock output
    logic clkport_q;
    logic scl_hold;

    assign scl_hold = two_wire & (start_hold_in
                    | ((wm == usis_pkg::USIS_WM_TWO_HOLD_E) & ovf_q));

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rise_prev_q      <= 1'b0;
            fall_prev_q      <= 1'b0;
            clk_strobe_sel_q <= 1'b0;
            data_q           <= `USIS_DATA_RST;
            cnt_q            <= `USIS_CNT_RST;
            ovf_q            <= 1'b0;
            out_q            <= 1'b0;
            clkport_q        <= 1'b0;
        end else begin
            rise_prev_q      <= sync_lvl[0];
            fall_prev_q      <= sync_lvl[1];
            clk_strobe_sel_q <= ctrl_wr_in ? shift_strobe_in : clk_strobe_sel_q;
            data_q           <= data_d;
            cnt_q            <= cnt_d;
            ovf_q            <= ovf_d;
            out_q            <= out_d;
            clkport_q        <= clkport_q ^ toggle_wr;
        end
    end

    // ==========================================================
    // Outputs
    assign shift_data_reg_out        = data_q;
    assign serial_status_reg_out     = {1'b0, ovf_q, 2'h0, cnt_q};
    assign counter_overflow_flag_out = ovf_q;
    assign idle_wake_out             = ovf_q & ovf_wake_enable_in;
    assign data_pin_out              = out_q;
    assign data_pin_oe_n_out         = ~(data_dir_in & ~two_wire);
    // Open drain: only ever pulls low, no slew or filter stage
    assign sda_pin_out               = 1'b0;
    assign sda_pin_oe_n_out          = ~(two_wire & data_dir_in & ~out_q);
    assign serial_clock_pin_out      = two_wire ? 1'b0 : clkport_q;
    assign serial_clock_pin_oe_n_out = two_wire ? ~(scl_hold | (clock_dir_in & ~clkport_q))
                                                : ~clock_dir_in;

    // ==========================================================
    // Checks
    sequence s_last_edge;
        (cnt_q == `USIS_CNT_TOP) && (cnt_inc == 2'h1) && !status_wr_in;
    endsequence

    sequence s_wrapped;
        ovf_q && (cnt_q == `USIS_CNT_RST);
    endsequence

    chk_write_beats_shift: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        data_wr_in |=> shift_data_reg_out == $past(data_wdata_in))
        else $error("data write lost to a shift");

    chk_soft_shift_bit: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (soft_shift && !data_wr_in)
        |=> shift_data_reg_out == {$past(data_q[`USIS_DATA_W-2:0]), $past(din_s)})
        else $error("software strobe did not shift one bit");

    chk_wrap_sets_flag: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        s_last_edge |=> s_wrapped)
        else $error("wrap from fifteen did not set overflow");

    chk_flag_clear_load: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (status_wr_in && status_wdata_in[`USIS_OVF_BIT] && !ovf_set)
        |=> !ovf_q && cnt_q == $past(status_wdata_in[`USIS_CNT_MSB:`USIS_CNT_LSB]))
        else $error("status write did not clear flag and load counter");

    chk_toggle_counts: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (toggle_wr && cnt_from_toggle && !status_wr_in)
        |=> clkport_q != $past(clkport_q) && cnt_q == $past(cnt_q) + 4'h1)
        else $error("toggle write did not invert clock and count");

    chk_mode0_shift: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (ext_sel && !clock_edge_select_in && rise_ev && !data_wr_in)
        |=> shift_data_reg_out == {$past(data_q[`USIS_DATA_W-2:0]), $past(rise_bit_q)})
        else $error("mode 0 rising edge did not shift its sample");

    chk_mode1_shift: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (ext_sel && clock_edge_select_in && fall_ev && !data_wr_in)
        |=> shift_data_reg_out == {$past(data_q[`USIS_DATA_W-2:0]), $past(fall_bit_q)})
        else $error("mode 1 falling edge did not shift its sample");

    chk_latch_open_int: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        !ext_sel |=> data_pin_out == shift_data_reg_out[`USIS_DATA_W-1])
        else $error("output latch closed under internal clock");

    chk_scl_stretch: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        ((wm == usis_pkg::USIS_WM_TWO_HOLD_E) && ovf_q)
        |-> !serial_clock_pin_oe_n_out && !serial_clock_pin_out)
        else $error("clock not held low after overflow");

    chk_edge_count: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (ext_sel && !clk_strobe_sel_q && (rise_ev || fall_ev) && !status_wr_in && cnt_q < 4'he)
        |=> cnt_q == $past(cnt_q) + {3'h0, $past(rise_ev)} + {3'h0, $past(fall_ev)})
        else $error("pin edges not counted");

endmodule : usis_top

// ==== usis_spi_master.sv ====
/*
 * Three-wire master model facing the serial shifter: drives the serial clock and data line, samples the reply.
 * Assumes a start pulse and a byte from the bench; it runs on its own 64 ns tick, unrelated to the system clock.
 */
`timescale 1ns/1ns

module usis_spi_master (
    input  wire logic       start_in,
    input  wire logic       mode_in,
    input  wire logic [7:0] tx_in,
    input  wire logic       miso_in,
    output logic            sck_out,
    output logic            mosi_out,
    output logic [7:0]      rx_out,
    output logic            busy_out
);
    logic tick = 1'b0;

    // ==========================================================
    // Base oscillator
    // Four ticks to a half period keep edges 256 ns apart, above the shifter's 160 ns floor
    initial begin
        #11;
        forever #32 tick = ~tick;
    end

    task automatic half_cycle();
        repeat (4) @(posedge tick);
    endtask : half_cycle

    // ==========================================================
    // Frames
    // Released data line keeps changing so that it cannot look like a held bit
    initial begin
        sck_out  = 1'b0;
        mosi_out = 1'b0;
        rx_out   = 8'h00;
        busy_out = 1'b0;
        forever begin
            while (start_in !== 1'b1) begin
                @(posedge tick or posedge start_in);
                if (start_in !== 1'b1) mosi_out = ~mosi_out;
            end
            busy_out = 1'b1;
            for (int i = 7; i >= 0; i--) begin
                if (!mode_in) mosi_out = tx_in[i];
                half_cycle();
                sck_out = 1'b1;
                if (mode_in) mosi_out = tx_in[i];
                else rx_out = {rx_out[6:0], miso_in};
                half_cycle();
                sck_out = 1'b0;
                if (mode_in) rx_out = {rx_out[6:0], miso_in};
            end
            half_cycle();
            busy_out = 1'b0;
        end
    end
endmodule : usis_spi_master

// ==== tb_universal_serial_shifter.sv ====
/*
 * Self-checking bench of the universal serial shifter with a master model on the serial side.
 * Assumes the design files and usis_spi_master.sv are compiled before it.
 */
`timescale 1ns/1ns
`include "usis_cfg.svh"

module tb_universal_serial_shifter;
    logic       clk, rst_n, lclk, din, tdin, ext, esel, wake_en, cwr, ss, tc, dwr, swr, ddir, cdir, hold;
    logic       flg, wake, dpin, dpin_oe_n, sda, sda_oe_n, spin, spin_oe_n, go, sck, mosi, busy, exp_sck;
    logic [1:0] wm, src;
    logic [7:0] wd, sd, q, st, exp_q, mtx, dev, mrx;
    int         fails = 0;
    int         n_compared = 0;
    int         cycles = 0;

    // Source 2 loops the pins back so that toggle writes really clock the shifter
    assign lclk = (src == 2'h2) ? spin : sck;
    assign din  = (src == 2'h2) ? dpin : ((src == 2'h1) ? tdin : mosi);

    usis_top dut (.sys_clk_in(clk), .arst_n_in(rst_n), .link_clk_in(lclk), .serial_data_in_in(din),
        .wire_mode_in(wm), .external_clock_select_in(ext), .clock_edge_select_in(esel),
        .ovf_wake_enable_in(wake_en), .ctrl_wr_in(cwr), .shift_strobe_in(ss), .clock_toggle_strobe_in(tc),
        .data_wr_in(dwr), .data_wdata_in(wd), .status_wr_in(swr), .status_wdata_in(sd),
        .data_dir_in(ddir), .clock_dir_in(cdir), .start_hold_in(hold), .shift_data_reg_out(q),
        .serial_status_reg_out(st), .counter_overflow_flag_out(flg), .idle_wake_out(wake),
        .data_pin_out(dpin), .data_pin_oe_n_out(dpin_oe_n), .sda_pin_out(sda), .sda_pin_oe_n_out(sda_oe_n),
        .serial_clock_pin_out(spin), .serial_clock_pin_oe_n_out(spin_oe_n));
    usis_spi_master peer (.start_in(go), .mode_in(esel), .tx_in(mtx), .miso_in(dpin), .sck_out(sck),
        .mosi_out(mosi), .rx_out(mrx), .busy_out(busy));

    // ==========================================================
    // Clock, timeout and reporting
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // One-cycle write strobes; the same byte goes to data and status
    task automatic strobe(input logic c, input logic d, input logic s, input logic [7:0] v);
        {cwr, dwr, swr, wd, sd} = {c, d, s, v, v};
        tick(1);
        {cwr, dwr, swr, ss, tc} = 5'h00;
        tick(1);
    endtask : strobe

    task automatic sw_shift();
        ss = 1'b1;
        strobe(1'b1, 1'b0, 1'b0, 8'h00);
    endtask : sw_shift

    // ==========================================================
    // Scenarios
    initial begin
        {rst_n, cwr, ss, tc, dwr, swr, hold, go, tdin, ext, esel, wake_en, ddir, cdir} = '0;
        {wm, src, wd, sd, mtx} = {2'h1, 2'h1, 24'h000000};
        void'($urandom(56224));
        tick(6);
        rst_n = 1'b1;
        tick(2);
        cmp8(q, `USIS_DATA_RST);
        cmp8(st, 8'h00);
        ddir = 1'b1;
        strobe(1'b0, 1'b1, 1'b0, 8'h80);
        cmp1(dpin, 1'b1);
        cmp1(dpin_oe_n, 1'b0);
        strobe(1'b0, 1'b1, 1'b0, 8'h7f);
        cmp1(dpin, 1'b0);
        // Software clocked shifts; the input waits out the pin synchroniser
        dev = $urandom;
        mtx = $urandom;
        strobe(1'b0, 1'b0, 1'b1, 8'h40);
        strobe(1'b0, 1'b1, 1'b0, dev);
        exp_q = dev;
        for (int i = 0; i < 8; i++) begin
            tdin = mtx[7-i];
            tick(5);
            sw_shift();
            exp_q = {exp_q[6:0], mtx[7-i]};
            cmp8(q, exp_q);
            cmp8(st, 8'(i + 1));
            cmp1(dpin, exp_q[7]);
        end
        wake_en = 1'b1;
        strobe(1'b0, 1'b0, 1'b1, 8'h0f);
        cmp8(st, 8'h0f);
        sw_shift();
        cmp8(st, 8'h40);
        cmp1(flg, 1'b1);
        cmp1(wake, 1'b1);
        wake_en = 1'b0;
        tick(1);
        cmp1(wake, 1'b0);
        strobe(1'b0, 1'b0, 1'b1, 8'h43);
        cmp8(st, 8'h03);
        ss = 1'b1;
        strobe(1'b1, 1'b1, 1'b0, 8'h5a);
        cmp8(q, 8'h5a);
        // Pin clocked slave, edge mode 0 then 1, corner bytes first
        {ext, src} = {1'b1, 2'h0};
        strobe(1'b1, 1'b0, 1'b0, 8'h00);
        for (int k = 0; k < 6; k++) begin
            esel = (k >= 3);
            dev = (k % 3 == 0) ? 8'h81 : 8'($urandom);
            mtx = (k % 3 == 0) ? 8'h7e : 8'($urandom);
            strobe(1'b0, 1'b1, 1'b0, dev);
            strobe(1'b0, 1'b0, 1'b1, 8'h40);
            go = 1'b1;
            tick(1);
            go = 1'b0;
            for (int w = 0; w < 400 && busy; w++) tick(1);
            tick(6);
            cmp8(q, mtx);
            cmp8(mrx, dev);
            cmp8(st, 8'h40);
        end
        // Count from toggle writes with the clock pin looped back
        {esel, src, cdir, exp_sck} = {1'b0, 2'h2, 1'b1, 1'b0};
        dev = $urandom;
        ss = 1'b1;
        strobe(1'b1, 1'b0, 1'b0, 8'h00);
        strobe(1'b0, 1'b1, 1'b0, dev);
        strobe(1'b0, 1'b0, 1'b1, 8'h40);
        for (int i = 0; i < 16; i++) begin
            {ss, tc} = 2'h3;
            strobe(1'b1, 1'b0, 1'b0, 8'h00);
            exp_sck = ~exp_sck;
            cmp1(spin, exp_sck);
            tick(6);
            cmp8(st, (i == 15) ? 8'h40 : 8'(i + 1));
        end
        cmp8(q, dev);
        // Two-wire with hold on overflow
        {src, ext, cdir, wm} = {2'h1, 1'b0, 1'b0, 2'h3};
        strobe(1'b0, 1'b0, 1'b1, 8'h40);
        strobe(1'b0, 1'b1, 1'b0, 8'h00);
        cmp1(sda, 1'b0);
        cmp1(sda_oe_n, 1'b0);
        cmp1(dpin_oe_n, 1'b1);
        cmp1(spin_oe_n, 1'b1);
        hold = 1'b1;
        tick(2);
        cmp1(spin_oe_n, 1'b0);
        cmp1(spin_oe_n ? 1'b1 : spin, 1'b0);
        hold = 1'b0;
        strobe(1'b0, 1'b0, 1'b1, 8'h0f);
        sw_shift();
        cmp1(spin_oe_n, 1'b0);
        strobe(1'b0, 1'b0, 1'b1, 8'h40);
        cmp1(spin_oe_n, 1'b1);
        strobe(1'b0, 1'b1, 1'b0, 8'h80);
        cmp1(sda_oe_n, 1'b1);
        end_of_test();
    end
endmodule : tb_universal_serial_shifter
